/* File: hw/adc_offset_gain_calibration.sv */
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
module adc_offset_gain_calibration (
    input  wire logic        I_CLK,
    input  wire logic        I_RST_B,
    input  wire logic [15:0] I_ADDR,
    input  wire logic [31:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [31:0] O_RDATA,
    input  wire logic        I_RAW_VALID,
    input  wire logic [15:0] I_ADC_RESULT_WORD,
    input  wire logic [1:0]  I_CHANNEL,
    input  wire logic [2:0]  I_PGA_GAIN,
    output logic             O_CAL_VALID,
    output logic      [15:0] O_CAL_RESULT,
    output logic             O_UNLOCKED
);

    logic [31:0] key_ff;
    logic [14:0] offset_ff [adc_cal_pkg::SLOTS];
    logic [14:0] gain_ff   [adc_cal_pkg::SLOTS];
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        unlocked;
    adc_cal_pkg::dec_s wr_dec;
    adc_cal_pkg::dec_s rd_dec;
    adc_cal_pkg::slot_e  sel_slot;
    adc_cal_pkg::chan_e  chan;
    adc_cal_pkg::pga_e   pga;

    adc_cal_if cal ();

    // All checks share the bus clock and reset
    default clocking chk_cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_B);

    // Map a byte address to a storage slot
    function automatic adc_cal_pkg::dec_s decode(input logic [15:0] a);
        adc_cal_pkg::dec_s d;
        d = '{hit: 1'b1, is_key: 1'b0, is_gain: 1'b0, slot: adc_cal_pkg::SLOT_LP};
        unique case (a)
            adc_cal_pkg::A_LOCK: begin
                d.is_key = 1'b1;
            end
            adc_cal_pkg::A_LP_OFS: begin
                d.slot = adc_cal_pkg::SLOT_LP;
            end
            adc_cal_pkg::A_LP_GAIN: begin
                d.slot    = adc_cal_pkg::SLOT_LP;
                d.is_gain = 1'b1;
            end
            adc_cal_pkg::A_HS_OFS: begin
                d.slot = adc_cal_pkg::SLOT_HS;
            end
            adc_cal_pkg::A_HS_GAIN: begin
                d.slot    = adc_cal_pkg::SLOT_HS;
                d.is_gain = 1'b1;
            end
            adc_cal_pkg::A_TEMP_OFS: begin
                d.slot = adc_cal_pkg::SLOT_TEMP;
            end
            adc_cal_pkg::A_TEMP_GAIN: begin
                d.slot    = adc_cal_pkg::SLOT_TEMP;
                d.is_gain = 1'b1;
            end
            adc_cal_pkg::A_G1_OFS: begin
                d.slot = adc_cal_pkg::SLOT_G1;
            end
            adc_cal_pkg::A_G1_GAIN: begin
                d.slot    = adc_cal_pkg::SLOT_G1;
                d.is_gain = 1'b1;
            end
            adc_cal_pkg::A_G1P5_OFS: begin
                d.slot = adc_cal_pkg::SLOT_G1P5;
            end
            adc_cal_pkg::A_G1P5_GAIN: begin
                d.slot    = adc_cal_pkg::SLOT_G1P5;
                d.is_gain = 1'b1;
            end
            adc_cal_pkg::A_G2_OFS: begin
                d.slot = adc_cal_pkg::SLOT_G2;
            end
            adc_cal_pkg::A_G2_GAIN: begin
                d.slot    = adc_cal_pkg::SLOT_G2;
                d.is_gain = 1'b1;
            end
            adc_cal_pkg::A_G4_OFS: begin
                d.slot = adc_cal_pkg::SLOT_G4;
            end
            adc_cal_pkg::A_G4_GAIN: begin
                d.slot    = adc_cal_pkg::SLOT_G4;
                d.is_gain = 1'b1;
            end
            adc_cal_pkg::A_G9_OFS: begin
                d.slot = adc_cal_pkg::SLOT_G9;
            end
            adc_cal_pkg::A_G9_GAIN: begin
                d.slot    = adc_cal_pkg::SLOT_G9;
                d.is_gain = 1'b1;
            end
            default: begin
                d.hit = 1'b0;
            end
        endcase
        return d;
    endfunction

    assign wr_dec = decode(I_ADDR);
    assign rd_dec = wr_dec;

    // Unlock is a compare against the stored key, so writing any other value to the lock register relocks
    assign unlocked = (key_ff == adc_cal_pkg::UNLOCK_KEY);

    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            key_ff <= adc_cal_pkg::KEY_RST;
        end else if (I_WR && wr_dec.hit && wr_dec.is_key) begin
            key_ff <= I_WDATA;
        end
    end

    // Calibration words; writes while locked leave the stored value alone
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            for (int i = 0; i < adc_cal_pkg::SLOTS; i++) begin
                offset_ff[i] <= adc_cal_pkg::OFS_RST;
                gain_ff[i]   <= adc_cal_pkg::GAIN_RST;
            end
        end else if (I_WR && wr_dec.hit && !wr_dec.is_key && unlocked) begin
            if (wr_dec.is_gain) begin
                gain_ff[wr_dec.slot] <= I_WDATA[14:0];
            end else begin
                offset_ff[wr_dec.slot] <= I_WDATA[14:0];
            end
        end
    end

    // Read path; data stands only in the cycle after the strobe
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (I_RD && rd_dec.hit) begin
            if (rd_dec.is_key) begin
                nxt_rdata = key_ff;
            end else if (rd_dec.is_gain) begin
                nxt_rdata = {17'h00000, gain_ff[rd_dec.slot]};
            end else begin
                nxt_rdata = {17'h00000, offset_ff[rd_dec.slot]};
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Pick the word pair that matches the active channel
    assign chan = adc_cal_pkg::chan_e'(I_CHANNEL);
    assign pga  = adc_cal_pkg::pga_e'(I_PGA_GAIN);

    always_comb begin
        sel_slot = adc_cal_pkg::SLOT_G1;
        unique case (chan)
            adc_cal_pkg::CH_LOW_POWER_TRANSIMP: begin
                sel_slot = adc_cal_pkg::SLOT_LP;
            end
            adc_cal_pkg::CH_HIGH_SPEED_TRANSIMP: begin
                sel_slot = adc_cal_pkg::SLOT_HS;
            end
            adc_cal_pkg::CH_TEMPERATURE: begin
                sel_slot = adc_cal_pkg::SLOT_TEMP;
            end
            adc_cal_pkg::CH_AUX: begin
                // Unknown gain codes fall back to unity rather than a stale pair
                case (pga)
                    adc_cal_pkg::PGA_1P5: sel_slot = adc_cal_pkg::SLOT_G1P5;
                    adc_cal_pkg::PGA_2:   sel_slot = adc_cal_pkg::SLOT_G2;
                    adc_cal_pkg::PGA_4:   sel_slot = adc_cal_pkg::SLOT_G4;
                    adc_cal_pkg::PGA_9:   sel_slot = adc_cal_pkg::SLOT_G9;
                    default:              sel_slot = adc_cal_pkg::SLOT_G1;
                endcase
            end
        endcase
    end

    assign cal.raw_valid = I_RAW_VALID;
    assign cal.raw       = I_ADC_RESULT_WORD;
    assign cal.offset    = offset_ff[sel_slot];
    assign cal.gain      = gain_ff[sel_slot];
    assign cal.transimp  = (chan == adc_cal_pkg::CH_LOW_POWER_TRANSIMP)
                        || (chan == adc_cal_pkg::CH_HIGH_SPEED_TRANSIMP);

    adc_cal_corrector u_corr (
        .i_clk   (I_CLK),
        .i_rst_b (I_RST_B),
        .cal     (cal.corr)
    );

    assign O_RDATA      = rdata_ff;
    assign O_CAL_VALID  = cal.res_valid;
    assign O_CAL_RESULT = cal.res;
    assign O_UNLOCKED   = unlocked;

    // Helper views for the checks below
    logic               wr_cal;
    logic [14:0]        wr_cur;
    logic [14:0]        wr_prev;
    logic               wr_gain_ff;
    adc_cal_pkg::slot_e wr_slot_ff;
    assign wr_cal  = I_WR && wr_dec.hit && !wr_dec.is_key;
    assign wr_cur  = wr_dec.is_gain ? gain_ff[wr_dec.slot] : offset_ff[wr_dec.slot];
    assign wr_prev = wr_gain_ff ? gain_ff[wr_slot_ff] : offset_ff[wr_slot_ff];

    // The address may move on after a write, so remember which word it named
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            wr_gain_ff <= 1'b0;
            wr_slot_ff <= adc_cal_pkg::SLOT_LP;
        end else begin
            wr_gain_ff <= wr_dec.is_gain;
            wr_slot_ff <= wr_dec.slot;
        end
    end

    a_unlock_key: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_WR && I_ADDR == adc_cal_pkg::A_LOCK && I_WDATA == adc_cal_pkg::UNLOCK_KEY
        |=> O_UNLOCKED)
        else $error("Key write did not unlock");

    a_relock_other: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_WR && I_ADDR == adc_cal_pkg::A_LOCK && I_WDATA != adc_cal_pkg::UNLOCK_KEY
        |=> !O_UNLOCKED)
        else $error("Non-key write left the bank unlocked");

    a_locked_write_kept: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        wr_cal && !unlocked |=> wr_prev == $past(wr_cur))
        else $error("Calibration word changed while locked");

    a_unlocked_write_takes: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        wr_cal && unlocked |=> wr_prev == $past(I_WDATA[14:0]))
        else $error("Unlocked write not stored");

    a_reserved_read_zero: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_RD && wr_cal == 1'b0 && rd_dec.hit && !rd_dec.is_key
        |=> O_RDATA[31:15] == 17'h00000)
        else $error("Reserved bits read non-zero");

    a_reset_values: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        $rose(I_RST_B) |-> key_ff == 32'h0000_0000 && gain_ff[0] == 15'h4000
        && offset_ff[7] == 15'h0000 && gain_ff[7] == 15'h4000)
        else $error("Registers not at reset values after reset");

    a_read_one_cycle: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        !I_RD |=> O_RDATA == 32'h0000_0000)
        else $error("Read data stood without a read strobe");

    a_hs_slot_used: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        chan == adc_cal_pkg::CH_HIGH_SPEED_TRANSIMP |-> cal.offset == offset_ff[1]
        && cal.gain == gain_ff[1])
        else $error("High speed channel not using its own pair");

    a_aux_gain_slot: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        chan == adc_cal_pkg::CH_AUX && pga == adc_cal_pkg::PGA_9
        |-> cal.gain == gain_ff[7])
        else $error("Gain nine setting not using its own pair");

    a_lp_slot_used: assert property (
        chan == adc_cal_pkg::CH_LOW_POWER_TRANSIMP
        |-> cal.offset == offset_ff[0] && cal.gain == gain_ff[0])
        else $error("Low power channel not using its own pair");

    a_temp_slot_used: assert property (
        chan == adc_cal_pkg::CH_TEMPERATURE
        |-> cal.offset == offset_ff[2] && cal.gain == gain_ff[2])
        else $error("Temperature channel not using its own pair");

    a_aux_unity_slot: assert property (
        chan == adc_cal_pkg::CH_AUX && (I_PGA_GAIN == 3'h0 || I_PGA_GAIN > 3'h4)
        |-> cal.offset == offset_ff[3] && cal.gain == gain_ff[3])
        else $error("Unity gain setting not using its own pair");

    a_aux_half_slot: assert property (
        chan == adc_cal_pkg::CH_AUX && I_PGA_GAIN == 3'h1
        |-> cal.offset == offset_ff[4] && cal.gain == gain_ff[4])
        else $error("Gain one and a half setting not using its own pair");

    a_aux_two_slot: assert property (
        chan == adc_cal_pkg::CH_AUX && I_PGA_GAIN == 3'h2
        |-> cal.offset == offset_ff[5] && cal.gain == gain_ff[5])
        else $error("Gain two setting not using its own pair");

    a_aux_four_slot: assert property (
        chan == adc_cal_pkg::CH_AUX && I_PGA_GAIN == 3'h3
        |-> cal.offset == offset_ff[6] && cal.gain == gain_ff[6])
        else $error("Gain four setting not using its own pair");

    a_aux_nine_offset: assert property (
        chan == adc_cal_pkg::CH_AUX && I_PGA_GAIN == 3'h4
        |-> cal.offset == offset_ff[7])
        else $error("Gain nine setting not using its own offset");

    a_key_readback: assert property (
        I_RD && rd_dec.is_key
        |=> O_RDATA == $past(key_ff))
        else $error("Lock register read did not return the key");

    a_word_readback: assert property (
        I_RD && rd_dec.hit && !rd_dec.is_key
        |=> O_RDATA == {17'h00000, $past(wr_cur)})
        else $error("Calibration word read did not return the stored value");

    a_unmapped_read_zero: assert property (
        I_RD && !rd_dec.hit
        |=> O_RDATA == 32'h0000_0000)
        else $error("Unmapped read returned data");

    a_key_write_stored: assert property (
        I_WR && wr_dec.is_key
        |=> key_ff == $past(I_WDATA))
        else $error("Lock register write not stored");

    a_valid_one_cycle: assert property (
        O_CAL_VALID == $past(I_RAW_VALID))
        else $error("Result valid does not follow raw valid by one cycle");

    a_result_held: assert property (
        !I_RAW_VALID
        |=> $stable(O_CAL_RESULT))
        else $error("Corrected result changed without a new sample");

    c_unlock_then_write: cover property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_WR && I_ADDR == adc_cal_pkg::A_LOCK && I_WDATA == adc_cal_pkg::UNLOCK_KEY
        ##1 wr_cal);

    c_locked_write: cover property (@(posedge I_CLK) disable iff (!I_RST_B)
        wr_cal && !unlocked);

    c_aux_result: cover property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_RAW_VALID && chan == adc_cal_pkg::CH_AUX ##1 O_CAL_VALID);

    c_tia_zero: cover property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_RAW_VALID && cal.transimp && cal.gain == 15'h0000);

endmodule // adc_offset_gain_calibration

/* File: common/adc_cal_pkg.sv */
// Overview of operation
// - Writing key 0xDE87A5AF to the lock register unlocks the calibration words.
// - Lock register is 32-bit read/write, resets to zero, guards calibration words.
// - Offset words hold 15-bit twos complement in bits 14..0; upper bits read zero.
// - One offset count equals a quarter of one result LSB.
// - Offset 0x3FFF is +4095.75, 0x4000 is -4096.0, 0x7FFF is -0.25.
// - Offset zero, the reset value, leaves the result unchanged.
// - Gain 0x4000 multiplies by exactly one and is the reset value.
// - Gain 0x7FFF multiplies by about two, 0x2000 by one half.
// - Gain scales linearly in steps of 1/16384.
// - Gain zero is illegal; on transimpedance channels the result is forced to zero.
// - Low power, high speed and temperature channels each use their own word pair.
// - Auxiliary channels use a separate pair for amplifier gains 1, 1.5, 2, 4, 9.
// - High speed offset applies to results taken in high speed mode.
// - Gains reset to 0x4000; offsets and lock register reset to zero.
// - Unity auxiliary gain word serves all non-transimpedance, non-temperature channels at gain one.
// - Gain word has bit 14 as top bit and bits 13..0 as fraction.
package adc_cal_pkg;

    localparam int unsigned ADDR_W    = 16;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned RESULT_W  = 16;
    localparam int unsigned CAL_W     = 15;
    localparam int unsigned SLOTS     = 8;
    localparam int unsigned SLOT_W    = 3;
    localparam int unsigned OFS_FRAC  = 2;
    localparam int unsigned GAIN_FRAC = 14;

    localparam logic [31:0] UNLOCK_KEY = 32'hde87a5af;
    localparam logic [31:0] KEY_RST    = 32'h0000_0000;
    localparam logic [14:0] OFS_RST    = 15'h0000;
    localparam logic [14:0] GAIN_RST   = 15'h4000;

    localparam logic [15:0] A_LOCK      = 16'h2230;
    localparam logic [15:0] A_HS_OFS    = 16'h2234;
    localparam logic [15:0] A_TEMP_GAIN = 16'h2238;
    localparam logic [15:0] A_TEMP_OFS  = 16'h223c;
    localparam logic [15:0] A_G1_GAIN   = 16'h2240;
    localparam logic [15:0] A_G1_OFS    = 16'h2244;
    localparam logic [15:0] A_G1P5_GAIN = 16'h2270;
    localparam logic [15:0] A_G2_GAIN   = 16'h2274;
    localparam logic [15:0] A_G4_GAIN   = 16'h2278;
    localparam logic [15:0] A_HS_GAIN   = 16'h2284;
    localparam logic [15:0] A_LP_OFS    = 16'h2288;
    localparam logic [15:0] A_LP_GAIN   = 16'h228c;
    localparam logic [15:0] A_G9_GAIN   = 16'h2298;
    localparam logic [15:0] A_G2_OFS    = 16'h22c8;
    localparam logic [15:0] A_G1P5_OFS  = 16'h22cc;
    localparam logic [15:0] A_G9_OFS    = 16'h22d0;
    localparam logic [15:0] A_G4_OFS    = 16'h22d4;

    // Storage slot per channel type
    typedef enum logic [2:0] {
        SLOT_LP, SLOT_HS, SLOT_TEMP, SLOT_G1, SLOT_G1P5, SLOT_G2, SLOT_G4, SLOT_G9
    } slot_e;

    // Channel kind seen by the converter
    typedef enum logic [1:0] {
        CH_LOW_POWER_TRANSIMP, CH_HIGH_SPEED_TRANSIMP, CH_TEMPERATURE, CH_AUX
    } chan_e;

    // Amplifier gain code
    typedef enum logic [2:0] {
        PGA_1, PGA_1P5, PGA_2, PGA_4, PGA_9
    } pga_e;

    typedef struct packed {
        logic  hit;
        logic  is_key;
        logic  is_gain;
        slot_e slot;
    } dec_s;

endpackage

/* File: common/adc_cal_if.sv */
`timescale 1ns/1ns
interface adc_cal_if;
    logic        raw_valid;
    logic [15:0] raw;
    logic [14:0] offset;
    logic [14:0] gain;
    logic        transimp;
    logic        res_valid;
    logic [15:0] res;

    modport bank (output raw_valid, raw, offset, gain, transimp, input res_valid, res);
    modport corr (input raw_valid, raw, offset, gain, transimp, output res_valid, res);
endinterface

/* File: hw/adc_cal_corrector.sv */
`timescale 1ns/1ns
module adc_cal_corrector (
    input  wire logic   i_clk,
    input  wire logic   i_rst_b,
    adc_cal_if.corr     cal
);

    logic signed [18:0] sum;
    logic signed [34:0] prod;
    logic signed [18:0] scaled;
    logic        [15:0] nxt_res;
    logic        [15:0] res_ff;
    logic               res_valid_ff;

    // Saturate a wide signed value to the result word
    function automatic logic [15:0] sat16(input logic signed [18:0] v);
        if (v > 19'sd32767) begin
            return 16'h7fff;
        end else if (v < -19'sd32768) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction

    always_comb begin
        // Quarter LSB offset units, so raw is moved up two bits first
        sum    = 19'(signed'({cal.raw[15], cal.raw, 2'b00}))
               + 19'(signed'(cal.offset));
        // Gain is code/16384, always taken as non-negative
        prod   = 35'(sum) * 35'(signed'({1'b0, cal.gain}));
        scaled = 19'(prod >>> (adc_cal_pkg::OFS_FRAC + adc_cal_pkg::GAIN_FRAC));
        nxt_res = sat16(scaled);
        if (cal.transimp && cal.gain == 15'h0000) begin
            nxt_res = 16'h0000;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            res_ff <= 16'h0000;
        end else if (cal.raw_valid) begin
            res_ff <= nxt_res;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            res_valid_ff <= 1'b0;
        end else begin
            res_valid_ff <= cal.raw_valid;
        end
    end

    assign cal.res       = res_ff;
    assign cal.res_valid = res_valid_ff;

    a_unity_passthru: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        cal.raw_valid && cal.gain == 15'h4000 && cal.offset == 15'h0000
        |=> cal.res == $past(cal.raw))
        else $error("Unity gain and zero offset changed the result");

    a_half_gain: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        cal.raw_valid && cal.gain == 15'h2000 && cal.offset == 15'h0000
        |=> cal.res == 16'($signed($past(cal.raw)) >>> 1))
        else $error("Half gain did not halve the result");

    a_quarter_offset: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        cal.raw_valid && cal.gain == 15'h4000 && cal.offset == 15'h0004
        && cal.raw != 16'h7fff
        |=> cal.res == 16'($past(cal.raw) + 16'h0001))
        else $error("Four offset counts did not add one LSB");

    a_tia_zero_gain: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        cal.raw_valid && cal.transimp && cal.gain == 15'h0000
        |=> cal.res == 16'h0000)
        else $error("Zero gain on transimpedance channel not forced to zero");

    a_result_latency: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        cal.raw_valid |=> cal.res_valid ##1 (cal.res_valid == $past(cal.raw_valid)))
        else $error("Result valid not one cycle after raw valid");

    c_saturate: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        cal.raw_valid && cal.gain == 15'h7fff && cal.raw == 16'h7fff ##1 cal.res == 16'h7fff);

endmodule // adc_cal_corrector

/* File: tb/adc_offset_gain_calibration_tb.sv */
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp); \
    end \
end
module adc_offset_gain_calibration_tb;
    logic        clk;
    logic        rst_b;
    logic        wr;
    logic        rd;
    logic        raw_valid;
    logic        cal_valid;
    logic        unlocked;
    logic [15:0] addr;
    logic [15:0] raw;
    logic [15:0] cal_res;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [1:0]  chan;
    logic [2:0]  pga;
    int          err_count;
    int          n_compared;
    int          cycles;
    integer      seed = 32'hc9296bee;
    logic [15:0] amap [0:15];
    logic [14:0] shadow [0:15];
    logic [31:0] key_sh;
    logic [14:0] gtab [0:6] = '{15'h7fff, 15'h2000, 15'h4001, 15'h3fff, 15'h0001, 15'h0000, 15'h4000};
    logic [14:0] otab [0:5] = '{15'h3fff, 15'h4000, 15'h7fff, 15'h0001, 15'h0000, 15'h0004};

    adc_offset_gain_calibration u_dut (
        .I_CLK             (clk),
        .I_RST_B           (rst_b),
        .I_ADDR            (addr),
        .I_WDATA           (wdata),
        .I_WR              (wr),
        .I_RD              (rd),
        .O_RDATA           (rdata),
        .I_RAW_VALID       (raw_valid),
        .I_ADC_RESULT_WORD (raw),
        .I_CHANNEL         (chan),
        .I_PGA_GAIN        (pga),
        .O_CAL_VALID       (cal_valid),
        .O_CAL_RESULT      (cal_res),
        .O_UNLOCKED        (unlocked)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report();
        if (err_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Run needs about 1400 cycles; the 20000-cycle ceiling lies well above it and ends a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 20000) begin
            err_count++;
            final_report();
        end
    end

    // Floor after scaling, then clamp to the signed 16-bit result range
    function automatic logic [15:0] exp_res(input logic [15:0] r, input logic [14:0] o, input logic [14:0] g);
        longint s;
        s = longint'($signed(r)) * 4 + longint'($signed(o));
        s = (s * longint'(g)) >>> 16;
        if (s > 32767) return 16'h7fff;
        if (s < -32768) return 16'h8000;
        return s[15:0];
    endfunction

    function automatic int slot_of(input logic [1:0] c, input logic [2:0] p);
        if (c != 2'd3) return int'(c);
        if (p < 3'd5) return 3 + int'(p);
        return 3;
    endfunction

    function automatic logic [31:0] exp_read(input logic [15:0] a);
        if (a == adc_cal_pkg::A_LOCK) return key_sh;
        for (int i = 0; i < 16; i++) if (amap[i] == a) return {17'h0, shadow[i]};
        return 32'h0000_0000;
    endfunction

    task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
        for (int i = 0; i < 16; i++) if (amap[i] == a && key_sh === adc_cal_pkg::UNLOCK_KEY) shadow[i] = d[14:0];
        if (a == adc_cal_pkg::A_LOCK) key_sh = d;
    endtask

    task automatic rd_chk(input logic [15:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        `CHK(rdata, exp_read(a), "read data")
    endtask

    task automatic sample(input logic [1:0] c, input logic [2:0] p, input logic [15:0] r);
        logic [15:0] e;
        int          s;
        s = slot_of(c, p);
        e = exp_res(r, shadow[2*s], shadow[2*s+1]);
        @(posedge clk);
        raw       <= r;
        chan      <= c;
        pga       <= p;
        raw_valid <= 1'b1;
        @(posedge clk);
        raw_valid <= 1'b0;
        #1;
        `CHK(cal_valid, 1'b1, "result valid")
        `CHK(cal_res, e, "corrected result")
    endtask

    initial begin
        amap = '{adc_cal_pkg::A_LP_OFS, adc_cal_pkg::A_LP_GAIN, adc_cal_pkg::A_HS_OFS, adc_cal_pkg::A_HS_GAIN,
                 adc_cal_pkg::A_TEMP_OFS, adc_cal_pkg::A_TEMP_GAIN, adc_cal_pkg::A_G1_OFS, adc_cal_pkg::A_G1_GAIN,
                 adc_cal_pkg::A_G1P5_OFS, adc_cal_pkg::A_G1P5_GAIN, adc_cal_pkg::A_G2_OFS, adc_cal_pkg::A_G2_GAIN,
                 adc_cal_pkg::A_G4_OFS, adc_cal_pkg::A_G4_GAIN, adc_cal_pkg::A_G9_OFS, adc_cal_pkg::A_G9_GAIN};
        for (int i = 0; i < 16; i++) shadow[i] = i[0] ? adc_cal_pkg::GAIN_RST : adc_cal_pkg::OFS_RST;
        key_sh    = adc_cal_pkg::KEY_RST;
        rst_b     = 1'b0;
        wr        = 1'b0;
        rd        = 1'b0;
        raw_valid = 1'b0;
        addr      = 16'h0000;
        wdata     = 32'h0000_0000;
        raw       = 16'h0000;
        chan      = 2'd0;
        pga       = 3'd0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        `CHK(unlocked, 1'b0, "locked after reset")
        rd_chk(adc_cal_pkg::A_LOCK);
        for (int i = 0; i < 16; i++) rd_chk(amap[i]);
        // Reset words pass every setting through
        for (int c = 0; c < 4; c++) for (int p = 0; p < 8; p++)
            sample(c[1:0], p[2:0], 16'($random(seed)));
        wr_reg(adc_cal_pkg::A_LP_GAIN, 32'h0000_2000);
        rd_chk(adc_cal_pkg::A_LP_GAIN);
        rd_chk(16'h2232);
        rd_chk(16'h22fc);
        wr_reg(adc_cal_pkg::A_LOCK, adc_cal_pkg::UNLOCK_KEY);
        `CHK(unlocked, 1'b1, "unlocked by key")
        rd_chk(adc_cal_pkg::A_LOCK);
        // Boundary codes of both words on a transimpedance channel, zero gain included
        foreach (gtab[g]) foreach (otab[o]) begin
            wr_reg(adc_cal_pkg::A_LP_OFS, {17'h1ffff, otab[o]});
            wr_reg(adc_cal_pkg::A_LP_GAIN, {17'h0, gtab[g]});
            sample(2'd0, 3'd0, 16'h0100);
            sample(2'd0, 3'd0, 16'($random(seed)));
            sample(2'd0, 3'd0, 16'h7fff);
        end
        repeat (400) begin
            case ({$random(seed)} % 3)
                0: wr_reg(amap[{$random(seed)} % 16], $random(seed));
                1: rd_chk(amap[{$random(seed)} % 16]);
                default: sample(2'($random(seed)), 3'($random(seed)), 16'($random(seed)));
            endcase
        end
        wr_reg(adc_cal_pkg::A_LOCK, 32'h0000_0001);
        `CHK(unlocked, 1'b0, "relocked by other value")
        wr_reg(adc_cal_pkg::A_HS_GAIN, 32'h0000_1234);
        rd_chk(adc_cal_pkg::A_HS_GAIN);
        sample(2'd1, 3'd0, 16'h4000);
        rd_chk(adc_cal_pkg::A_LOCK);
        final_report();
    end
endmodule // adc_offset_gain_calibration_tb
